//--- hdl/chip_reset_sequencer.sv
// Chip reset sequencer: qualifies master reset, synchronises power-on reset, takes watchdog
// time-out; stretches SDRAM and system resets; selects the clock output.
// Assumes pin inputs are asynchronous to clk_sys; low_freq_clock is sampled.
`timescale 1ns/1ps

// Behaviour
// - Master reset is active low; holds all modules but reset and clock control.
// - Reset output low on power-on, master reset or watchdog time-out.
// - Power-on input is active high; any high level requests power-up reset.
// - Internal power-on reset held 300 ms of low-frequency clock.
// - SDRAM reset stretched 7 low-frequency cycles after power-on hold.
// - System reset and reset output stretched 14 cycles, released together.
// - Master reset qualified by 4 consecutive low-frequency samples.
// - Clock output pin driven from a selectable internal clock.
module chip_reset_sequencer #(
  parameter int unsigned HOLD_CYC = rst_seq_pkg::POR_HOLD_CYC,
  parameter int unsigned NCLK     = 4
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     low_freq_clock,
  input  wire logic                     master_reset_n,
  input  wire logic                     power_on_reset,
  input  wire logic                     watchdog_timeout,
  input  wire logic [NCLK-1:0]          clk_sources,
  input  wire logic [$clog2(NCLK)-1:0]  clk_out_sel,
  output rst_seq_pkg::rst_bundle_t      resets,
  output logic                          clock_output_pin
);

  localparam int CW = 14;

  // Two-flop synchronisers for pin inputs
  logic [1:0] lf_sync_reg;
  logic [1:0] mr_sync_reg;
  logic [1:0] por_sync_reg;
  logic       lf_prev_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lf_sync_reg  <= 2'h0;
      mr_sync_reg  <= 2'h3;
      por_sync_reg <= 2'h3;
      lf_prev_reg  <= 1'b0;
    end else begin
      lf_sync_reg  <= {lf_sync_reg[0], low_freq_clock};
      mr_sync_reg  <= {mr_sync_reg[0], master_reset_n};
      por_sync_reg <= {por_sync_reg[0], power_on_reset};
      lf_prev_reg  <= lf_sync_reg[1];
    end
  end

  // One-cycle tick per rising edge of the low-frequency clock
  logic lf_tick;
  assign lf_tick = lf_sync_reg[1] & ~lf_prev_reg;

  // Master reset qualifier counts consecutive low samples
  logic [2:0] qual_reg;
  logic       mr_qual;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qual_reg <= 3'h0;
    end else if (mr_sync_reg[1]) begin
      qual_reg <= 3'h0;
    end else if (lf_tick && qual_reg != 3'(rst_seq_pkg::QUAL_CYC)) begin
      qual_reg <= qual_reg + 3'h1;
    end
  end
  assign mr_qual = (qual_reg == 3'(rst_seq_pkg::QUAL_CYC));

  // Any cause restarts the sequence; power-on is active high
  logic cause;
  assign cause = por_sync_reg[1] | mr_qual | watchdog_timeout;

  rst_seq_pkg::seq_state_t state_reg;
  logic [CW-1:0]           cnt_reg;

  // Sequencer: hold, SDRAM stretch, system stretch, then run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rst_seq_pkg::ST_IDLE;
      cnt_reg   <= '0;
    end else if (cause) begin
      state_reg <= rst_seq_pkg::ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        rst_seq_pkg::ST_IDLE: begin
          state_reg <= rst_seq_pkg::ST_HOLD;
          cnt_reg   <= '0;
        end
        rst_seq_pkg::ST_HOLD: begin
          if (lf_tick) begin
            if (cnt_reg == CW'(HOLD_CYC - 1)) begin
              state_reg <= rst_seq_pkg::ST_SDRAM;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        rst_seq_pkg::ST_SDRAM: begin
          if (lf_tick) begin
            if (cnt_reg == CW'(rst_seq_pkg::SDRAM_CYC - 1)) begin
              state_reg <= rst_seq_pkg::ST_SYS;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        rst_seq_pkg::ST_SYS: begin
          // Counted from hold end, so system lags SDRAM by 7 more cycles
          if (lf_tick) begin
            if (cnt_reg == CW'(rst_seq_pkg::SYS_CYC - rst_seq_pkg::SDRAM_CYC - 1)) begin
              state_reg <= rst_seq_pkg::ST_RUN;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        rst_seq_pkg::ST_RUN: begin
          state_reg <= rst_seq_pkg::ST_RUN;
        end
        default: begin
          state_reg <= rst_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Registered reset outputs; module reset also follows qualified master reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resets <= '0;
    end else begin
      resets.sdram_rst_n <= !cause && (state_reg == rst_seq_pkg::ST_SYS ||
                            state_reg == rst_seq_pkg::ST_RUN);
      resets.internal_system_reset_n <= !cause &&
                            state_reg == rst_seq_pkg::ST_RUN;
      resets.module_rst_n <= !cause && state_reg == rst_seq_pkg::ST_RUN;
      resets.reset_out_n  <= !cause && state_reg == rst_seq_pkg::ST_RUN;
    end
  end

  // Clock output mux; glitches on selection change are the user's concern
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin <= 1'b0;
    end else begin
      clock_output_pin <= clk_sources[clk_out_sel];
    end
  end

  // Assertions
  // System reset and reset output always move together
  property p_sys_with_out;
    @(posedge clk_sys) disable iff (!rst_n)
      resets.internal_system_reset_n == resets.reset_out_n;
  endproperty
  a_sys_with_out: assert property (p_sys_with_out)
    else $error("system reset and reset output differ");
  property p_cause_resets;
    @(posedge clk_sys) disable iff (!rst_n) cause |=> !resets.reset_out_n;
  endproperty
  a_cause_resets: assert property (p_cause_resets)
    else $error("reset output not asserted on cause");
  property p_sdram_first;
    @(posedge clk_sys) disable iff (!rst_n)
      resets.internal_system_reset_n |-> resets.sdram_rst_n;
  endproperty
  a_sdram_first: assert property (p_sdram_first)
    else $error("system released before SDRAM");
  property p_por_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      por_sync_reg[1] |=> state_reg == rst_seq_pkg::ST_IDLE;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("power-on did not restart");
  // Qualifier clears one clock after the input returns high, so look back
  property p_qual;
    @(posedge clk_sys) disable iff (!rst_n) mr_qual |-> !$past(mr_sync_reg[1]);
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualified while input high");
  property p_hold_exit;
    @(posedge clk_sys) disable iff (!rst_n)
      state_reg == rst_seq_pkg::ST_SDRAM && $past(state_reg) == rst_seq_pkg::ST_HOLD
      |-> $past(cnt_reg) == CW'(HOLD_CYC - 1);
  endproperty
  a_hold_exit: assert property (p_hold_exit)
    else $error("hold left early");
  property p_sdram_exit;
    @(posedge clk_sys) disable iff (!rst_n)
      state_reg == rst_seq_pkg::ST_SYS && $past(state_reg) == rst_seq_pkg::ST_SDRAM
      |-> $past(cnt_reg) == CW'(rst_seq_pkg::SDRAM_CYC - 1);
  endproperty
  a_sdram_exit: assert property (p_sdram_exit)
    else $error("SDRAM stretch wrong");
  property p_mod_rst;
    @(posedge clk_sys) disable iff (!rst_n) mr_qual |=> !resets.module_rst_n;
  endproperty
  a_mod_rst: assert property (p_mod_rst)
    else $error("modules not held in master reset");
  property p_clkout;
    @(posedge clk_sys) disable iff (!rst_n)
      clock_output_pin == $past(clk_sources[clk_out_sel]);
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock output not from selected source");
  // Modules leave reset together with the reset output
  property p_mod_with_out;
    @(posedge clk_sys) disable iff (!rst_n)
      resets.module_rst_n == resets.reset_out_n;
  endproperty
  a_mod_with_out: assert property (p_mod_with_out)
    else $error("module reset and reset output differ");
  // A high master input wipes any partial qualifier count
  property p_qual_clear;
    @(posedge clk_sys) disable iff (!rst_n) mr_sync_reg[1] |=> qual_reg == 3'h0;
  endproperty
  a_qual_clear: assert property (p_qual_clear)
    else $error("qualifier kept count while input high");
  // Release steps: SDRAM comes out while the system side is still held
  sequence s_sdram_up;
    $rose(resets.sdram_rst_n);
  endsequence
  sequence s_sys_held;
    !resets.internal_system_reset_n && !resets.reset_out_n;
  endsequence
  property p_sys_after_sdram;
    @(posedge clk_sys) disable iff (!rst_n) s_sdram_up |-> s_sys_held;
  endproperty
  a_sys_after_sdram: assert property (p_sys_after_sdram)
    else $error("system released with SDRAM");

endmodule : chip_reset_sequencer

//--- hdl/rst_seq_pkg.sv
// Package for the chip reset sequencer: timing counts, states, carrier structs.
// Assumes a single system clock; slow timing comes from a low-frequency tick.
package rst_seq_pkg;

  // Low-frequency clock rate and system clock rate
  localparam int unsigned LF_HZ        = 32000;
  localparam int unsigned SYS_HZ       = 125000000;
  // Internal power-on hold, in ms, and as low-frequency cycles
  localparam int unsigned POR_HOLD_MS  = 300;
  localparam int unsigned POR_HOLD_CYC = (POR_HOLD_MS * LF_HZ) / 1000;
  // Stretchers and qualifier, in low-frequency cycles
  localparam int unsigned SDRAM_CYC    = 7;
  localparam int unsigned SYS_CYC      = 14;
  localparam int unsigned QUAL_CYC     = 4;
  // System clocks per low-frequency cycle
  localparam int unsigned LF_DIV       = SYS_HZ / LF_HZ;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_HOLD  = 3'h1,
    ST_SDRAM = 3'h2,
    ST_SYS   = 3'h3,
    ST_RUN   = 3'h4
  } seq_state_t;

  // Reset outputs travelling together
  typedef struct packed {
    logic sdram_rst_n;
    logic internal_system_reset_n;
    logic module_rst_n;
    logic reset_out_n;
  } rst_bundle_t;

endpackage : rst_seq_pkg

//--- verif/chip_reset_sequencer_tb_top.sv
// Self-checking bench for the chip reset sequencer.
// Assumes the supervisor model drives slow clock, power-on and master reset.
`timescale 1ns/1ps
module chip_reset_sequencer_tb_top;
  localparam int HOLD = 3;
  logic                     clk_sys;
  logic                     rst_n;
  logic                     low_freq_clock;
  logic                     master_reset_n;
  logic                     power_on_reset;
  logic                     watchdog_timeout;
  logic [3:0]               clk_sources;
  logic [1:0]               clk_out_sel;
  rst_seq_pkg::rst_bundle_t resets;
  logic                     clock_output_pin;
  int                       mismatches;
  int                       checked;

  chip_reset_sequencer #(.HOLD_CYC(HOLD), .NCLK(4)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .low_freq_clock(low_freq_clock),
    .master_reset_n(master_reset_n), .power_on_reset(power_on_reset),
    .watchdog_timeout(watchdog_timeout), .clk_sources(clk_sources),
    .clk_out_sel(clk_out_sel), .resets(resets), .clock_output_pin(clock_output_pin));

  rst_supervisor_model sup (.clk_sys(clk_sys), .low_freq_clock(low_freq_clock),
    .master_reset_n(master_reset_n), .power_on_reset(power_on_reset));

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Wait n slow ticks, then let the synchronisers settle
  task automatic ticks(input int n);
    repeat (n) @(posedge low_freq_clock);
    repeat (10) @(posedge clk_sys);
    #1;
  endtask : ticks

  // Full release order after the last cause clears
  task automatic seq_check();
    ticks(HOLD + 6);
    check("hold", resets, 4'h0);
    ticks(1);
    check("sdram_out", resets, 4'h8);
    ticks(6);
    check("sys_wait", resets, 4'h8);
    ticks(1);
    check("all_out", resets, 4'hF);
  endtask : seq_check

  // Watchdog pulse aligned to a slow tick; outputs must drop at once
  task automatic wd_pulse();
    @(posedge low_freq_clock);
    @(posedge clk_sys);
    #1 watchdog_timeout = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 watchdog_timeout = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check("wd_assert", resets, 4'h0);
  endtask : wd_pulse

  task automatic test_power_up();
    check("por_high", resets, 4'h0);
    sup.por_release();
    seq_check();
  endtask : test_power_up

  task automatic test_master();
    sup.master_pulse(3);
    ticks(2);
    check("short_master", resets, 4'hF);
    sup.master_pulse(4);
    // Qualifier completes a few clocks after the pin returns high
    repeat (5) @(posedge clk_sys);
    #1 check("master_hold", resets, 4'h0);
    seq_check();
  endtask : test_master

  // A second cause in the system stretch restarts from the start
  task automatic test_restart();
    wd_pulse();
    ticks(HOLD + 8);
    check("mid_seq", resets, 4'h8);
    wd_pulse();
    seq_check();
  endtask : test_restart

  task automatic test_clk_out();
    logic [3:0] pat;
    for (int s = 0; s < 8; s++) begin
      pat = (s < 4) ? 4'h5 : 4'hA;
      clk_sources = pat;
      clk_out_sel = s[1:0];
      repeat (2) @(posedge clk_sys);
      #1 check("clk_out", {3'h0, clock_output_pin}, {3'h0, pat[s[1:0]]});
    end
  endtask : test_clk_out

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Main sequence: reset held 20 cycles, then the scenarios
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    watchdog_timeout = 1'b0;
    clk_sources = 4'h0;
    clk_out_sel = 2'h0;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    test_power_up();
    test_master();
    test_restart();
    test_clk_out();
    finish_test();
  end

  // About 80 slow ticks are needed; allow well over twice that
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
endmodule : chip_reset_sequencer_tb_top

//--- verif/rst_supervisor_model.sv
// Model of the outside reset supervisor, power-on RC and 32 kHz source.
// Assumes the bench calls its tasks; slow clock is sped up for simulation.
`timescale 1ns/1ps
module rst_supervisor_model #(
  parameter int LF_HALF = 20
) (
  input  wire logic clk_sys,
  output logic      low_freq_clock,
  output logic      master_reset_n,
  output logic      power_on_reset
);
  // Power-on held high from time zero, covers oscillator start-up
  initial begin
    low_freq_clock = 1'b0;
    master_reset_n = 1'b1;
    power_on_reset = 1'b1;
  end

  // Free-running slow clock, edges just after the system clock edge
  always begin
    repeat (LF_HALF) @(posedge clk_sys);
    #1 low_freq_clock = ~low_freq_clock;
  end

  // Release power-on just after a slow tick so tick counts are exact
  task automatic por_release();
    @(posedge low_freq_clock);
    @(posedge clk_sys);
    #1 power_on_reset = 1'b0;
  endtask : por_release

  // Master reset low for n slow ticks; n below 4 breaks the minimum
  task automatic master_pulse(input int n);
    @(posedge low_freq_clock);
    @(posedge clk_sys);
    #1 master_reset_n = 1'b0;
    repeat (n) @(posedge low_freq_clock);
    @(posedge clk_sys);
    #1 master_reset_n = 1'b1;
  endtask : master_pulse
endmodule : rst_supervisor_model
